// >>> asq_pkg.sv
// Package: offsets, fields, reset values and timing of the scan sequencer
package asq_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned BURST_NS = 2000;
   localparam int unsigned BURST_CYC_I = (BURST_NS * CLK_MHZ + 999) / 1000;
   localparam logic [15:0] BURST_CYC = 16'(BURST_CYC_I);
   localparam int QDEPTH_DEF = 16;
   localparam int FDEPTH_DEF = 16;
   localparam int SAMPLE_W = 16;
   localparam int TAG_W = 4;
   localparam int FIFO_W = SAMPLE_W + TAG_W;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_CMD = 12'h004;
   localparam logic [11:0] OFF_ACQ_TRIGGER_IN = 12'h008;
   localparam logic [11:0] OFF_QLEN = 12'h00C;
   localparam logic [11:0] OFF_PACER = 12'h010;
   localparam logic [11:0] OFF_TCOUNT = 12'h014;
   localparam logic [11:0] OFF_STATUS = 12'h018;
   localparam logic [11:0] OFF_DATA = 12'h01C;
   localparam logic [5:0] OFF_QUEUE_HI = 6'h01;
   localparam int CTRL_EXT_SEL = 0;
   localparam int CTRL_BURST = 1;
   localparam int CTRL_RETRIG = 2;
   localparam int CTRL_ACQ_TRIGGER_IN_EN = 3;
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int ACQ_TRIGGER_IN_LEVEL = 0;
   localparam int ACQ_TRIGGER_IN_INVERT = 1;
   localparam int ST_OVERRUN = 16;
   localparam int DATA_VALID = 31;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [1:0] ACQ_TRIGGER_IN_RST = 2'h0;
   localparam logic [3:0] QLEN_RST = 4'h0;
   localparam logic [31:0] PACER_RST = 32'h0000_00FA;
   localparam logic [31:0] TCOUNT_RST = 32'h0000_0001;
   localparam int ENT_DIFF = 4;
   localparam int ENT_RANGE_LO = 5;
   localparam logic [1:0] RANGE_PM10_VOLT = 2'h0;
   localparam logic [1:0] RANGE_PM5_VOLT = 2'h1;
   localparam logic [1:0] RANGE_PM2_VOLT = 2'h2;
   localparam logic [1:0] RANGE_PM1_VOLT = 2'h3;
   localparam logic [6:0] ENTRY_RST = 7'h00;
endpackage : asq_pkg

// >>> asq_sync.sv
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/10ps
module asq_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_reg;

   initial begin
      if (W < 1) $error("asq_sync: W must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_reg <= '0;
         o_q <= '0;
      end else begin
         meta_reg <= i_d;
         o_q <= meta_reg;
      end
   end
endmodule : asq_sync

// >>> asq_fifo.sv
// Sample FIFO with flip-flop storage and valid/ready on both sides
`timescale 1ns/10ps
module asq_fifo #(
   parameter int W = 20,
   parameter int D = 16
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data,
   output logic [$clog2(D):0] o_level
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_reg [D];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   wire logic push = i_in_valid & o_in_ready;
   wire logic pop = o_out_valid & i_out_ready;

   initial begin
      if (D < 2 || (1 << AW) != D) $error("asq_fifo: D must be 2**n");
   end

   assign o_in_ready = cnt_reg != (AW+1)'(D);
   assign o_out_valid = cnt_reg != '0;
   assign o_out_data = mem_reg[rd_reg];
   assign o_level = cnt_reg;

   always_ff @(posedge i_clk) begin
      if (push) mem_reg[wr_reg] <= i_in_data;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : asq_fifo

// >>> asq_scan_seq.sv
// Analog scan sequencer: queue, pacing, trigger, clock echo, APB slave
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - Queue of 1 to 16 entries
// - Entries in any order, duplicates allowed
// - Sixteen single-ended channels or eight pairs
// - Stored queue is reused on every scan
// - External clock pulses echoed on clock output
// - Internal sample clock driven on clock output
// - Trigger detection selectable edge or level
// - Edge mode fires on rising or falling
// - Level mode active high or low
// - After reset: edge mode, rising transition
// - Retrigger mode rearms after each trigger
// - Exactly trigger-count samples per trigger
// - Burst spacing 2 us, else evenly spread
// - External pacing always forces burst mode
// - Run until stopped; start by command/trigger
module asq_scan_seq #(
   parameter int QDEPTH = asq_pkg::QDEPTH_DEF,
   parameter int FDEPTH = asq_pkg::FDEPTH_DEF
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   input wire logic i_ext_sample_clock_in,
   input wire logic i_acq_trigger_in,
   output logic o_sample_clock_echo_out,
   output logic o_conv_start,
   output logic [3:0] o_conv_chan,
   output logic o_conv_diff,
   output logic [1:0] o_conv_range,
   input wire logic i_conv_done,
   input wire logic [asq_pkg::SAMPLE_W-1:0] i_conv_data
);
   import asq_pkg::*;

   typedef enum logic [1:0] {ASQ_IDLE, ASQ_ARMED, ASQ_RUN} asq_state_e;

   initial begin
      if (QDEPTH < 1 || QDEPTH > 16) $error("asq_scan_seq: QDEPTH 1..16");
   end

   logic [3:0] ctrl_reg;
   logic [1:0] acq_trigger_in_reg;
   logic [3:0] qlen_reg;
   logic [31:0] pacer_reg;
   logic [31:0] tcount_reg;
   logic [6:0] queue_reg [QDEPTH];
   asq_state_e state_reg, state_next;
   logic [3:0] qidx_reg;
   logic [31:0] pcnt_reg;
   logic [32:0] acc_reg;
   logic [4:0] blft_reg;
   logic [15:0] bcnt_reg;
   logic pend_reg;
   logic busy_reg;
   logic [3:0] tag_reg;
   logic [31:0] tcnt_reg;
   logic ovr_reg;
   logic seen_reg;
   logic acq_trigger_in_d_reg;
   logic ext_d_reg;
   logic [1:0] pin_s;

   // APB decode
   wire logic apb_acc = i_psel & i_penable & ~o_pready;
   wire logic apb_done = i_psel & i_penable & o_pready;
   wire logic apb_wr = apb_done & i_pwrite;
   wire logic hit_ctrl = i_paddr == OFF_CTRL;
   wire logic hit_cmd = i_paddr == OFF_CMD;
   wire logic hit_acq_trigger_in = i_paddr == OFF_ACQ_TRIGGER_IN;
   wire logic hit_qlen = i_paddr == OFF_QLEN;
   wire logic hit_pacer = i_paddr == OFF_PACER;
   wire logic hit_tcount = i_paddr == OFF_TCOUNT;
   wire logic hit_status = i_paddr == OFF_STATUS;
   wire logic hit_data = i_paddr == OFF_DATA;
   wire logic [3:0] q_sel = i_paddr[5:2];
   wire logic hit_queue = (i_paddr[11:6] == OFF_QUEUE_HI)
                          && (i_paddr[1:0] == 2'h0)
                          && (int'(q_sel) < QDEPTH);
   wire logic hit_any = hit_ctrl | hit_cmd | hit_acq_trigger_in | hit_qlen | hit_pacer
                        | hit_tcount | hit_status | hit_data | hit_queue;

   // Configuration bits
   wire logic ext_sel = ctrl_reg[CTRL_EXT_SEL];
   wire logic retrig = ctrl_reg[CTRL_RETRIG];
   wire logic acq_trigger_in_en = ctrl_reg[CTRL_ACQ_TRIGGER_IN_EN];
   wire logic burst = ext_sel | ctrl_reg[CTRL_BURST];
   wire logic lvl_mode = acq_trigger_in_reg[ACQ_TRIGGER_IN_LEVEL];
   wire logic inv_mode = acq_trigger_in_reg[ACQ_TRIGGER_IN_INVERT];
   wire logic cmd_start = apb_wr & hit_cmd & i_pwdata[CMD_START];
   wire logic cmd_stop = apb_wr & hit_cmd & i_pwdata[CMD_STOP];

   // Pins pass two flip-flops before any logic reads them
   asq_sync #(.W(2)) u_sync (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_d({i_acq_trigger_in, i_ext_sample_clock_in}),
      .o_q(pin_s)
   );
   wire logic ext_s = pin_s[0];
   wire logic acq_trigger_in_s = pin_s[1];

   // Trigger detection
   wire logic acq_trigger_in_rise = acq_trigger_in_s & ~acq_trigger_in_d_reg;
   wire logic acq_trigger_in_fall = ~acq_trigger_in_s & acq_trigger_in_d_reg;
   wire logic acq_trigger_in_edge = inv_mode ? acq_trigger_in_fall : acq_trigger_in_rise;
   wire logic acq_trigger_in_lvl = acq_trigger_in_s ^ inv_mode;
   wire logic acq_trigger_in_fire = lvl_mode ? acq_trigger_in_lvl : acq_trigger_in_edge;

   // Pacing
   wire logic run = state_reg == ASQ_RUN;
   wire logic [4:0] n_ent = {1'b0, qlen_reg} + 5'h01;
   wire logic ext_tick = ext_sel & ext_s & ~ext_d_reg;
   wire logic int_tick = ~ext_sel & run & (pcnt_reg == '0);
   wire logic scan_tick = run & (ext_tick | int_tick);
   wire logic [32:0] acc_sum = acc_reg + {28'h0000000, n_ent};
   wire logic even_hit = run & ~burst & (acc_sum >= {1'b0, pacer_reg});
   wire logic burst_hit = run & burst & (blft_reg != '0)
                          & (bcnt_reg == '0);
   wire logic sample_tick = burst ? burst_hit : even_hit;

   // Conversion issue and per-trigger counting
   wire logic [FIFO_W-1:0] f_out_data;
   wire logic f_in_ready;
   wire logic f_out_valid;
   wire logic [$clog2(FDEPTH):0] f_level;
   wire logic issue = run & pend_reg & ~busy_reg & f_in_ready;
   wire logic counted = retrig & acq_trigger_in_en;
   wire logic rearm = counted & issue
                      & (tcnt_reg + 32'h1 >= tcount_reg);
   wire logic [6:0] entry = queue_reg[qidx_reg];
   wire logic pop = apb_done & ~i_pwrite & hit_data & seen_reg;
   wire logic push = busy_reg & i_conv_done;

   asq_fifo #(.W(FIFO_W), .D(FDEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(push),
      .o_in_ready(f_in_ready),
      .i_in_data({tag_reg, i_conv_data}),
      .o_out_valid(f_out_valid),
      .i_out_ready(pop),
      .o_out_data(f_out_data),
      .o_level(f_level)
   );

   // Read mux
   wire logic [31:0] status_w = {15'h0000, ovr_reg, 3'h0,
                                 5'(f_level), qidx_reg, 2'h0, state_reg};
   // Storage is not reset, so an empty buffer reads as zero, not unknown
   wire logic [31:0] data_w = f_out_valid ? {1'b1, 11'h000, f_out_data}
                              : 32'h00000000;
   wire logic [31:0] rd_mux =
      hit_ctrl   ? {28'h0000000, ctrl_reg} :
      hit_acq_trigger_in   ? {30'h00000000, acq_trigger_in_reg} :
      hit_qlen   ? {28'h0000000, qlen_reg} :
      hit_pacer  ? pacer_reg :
      hit_tcount ? tcount_reg :
      hit_status ? status_w :
      hit_data   ? data_w :
      hit_queue  ? {25'h0000000, queue_reg[q_sel]} : 32'h00000000;

   // Acquisition state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ASQ_IDLE: begin
            if (cmd_start) state_next = acq_trigger_in_en ? ASQ_ARMED : ASQ_RUN;
         end
         ASQ_ARMED: begin
            if (acq_trigger_in_fire) state_next = ASQ_RUN;
         end
         ASQ_RUN: begin
            if (rearm) state_next = ASQ_ARMED;
         end
         default: state_next = ASQ_IDLE;
      endcase
      if (cmd_stop) state_next = ASQ_IDLE;
   end

   // APB slave: two-cycle access, fixed answer
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
         seen_reg <= 1'b0;
      end else begin
         o_pready <= apb_acc;
         o_pslverr <= apb_acc & ~hit_any;
         if (apb_acc) o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
         if (apb_acc) seen_reg <= f_out_valid;
      end
   end

   // Software registers
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_reg <= CTRL_RST;
         acq_trigger_in_reg <= ACQ_TRIGGER_IN_RST;
         qlen_reg <= QLEN_RST;
         pacer_reg <= PACER_RST;
         tcount_reg <= TCOUNT_RST;
      end else if (apb_wr) begin
         if (hit_ctrl) ctrl_reg <= i_pwdata[3:0];
         if (hit_acq_trigger_in) acq_trigger_in_reg <= i_pwdata[1:0];
         if (hit_qlen) begin
            qlen_reg <= (int'(i_pwdata[3:0]) < QDEPTH) ? i_pwdata[3:0]
                        : 4'(QDEPTH - 1);
         end
         if (hit_pacer) pacer_reg <= (i_pwdata == '0) ? 32'h1 : i_pwdata;
         if (hit_tcount) tcount_reg <= (i_pwdata == '0) ? 32'h1 : i_pwdata;
      end
   end

   // Queue memory is written only by software and survives scans
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < QDEPTH; i++) queue_reg[i] <= ENTRY_RST;
      end else if (apb_wr & hit_queue) begin
         queue_reg[q_sel] <= i_pwdata[6:0];
      end
   end

   // Sequencing and pacing
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ASQ_IDLE;
         acq_trigger_in_d_reg <= 1'b0;
         ext_d_reg <= 1'b0;
         pcnt_reg <= '0;
         acc_reg <= '0;
         blft_reg <= '0;
         bcnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         acq_trigger_in_d_reg <= acq_trigger_in_s;
         ext_d_reg <= ext_s;
         if (!run || pcnt_reg == '0) pcnt_reg <= pacer_reg - 32'h1;
         else pcnt_reg <= pcnt_reg - 32'h1;
         // Accumulator spreads n samples evenly over one pacer period
         if (!run || burst) acc_reg <= '0;
         else if (even_hit) acc_reg <= acc_sum - {1'b0, pacer_reg};
         else acc_reg <= acc_sum;
         if (!run || rearm) blft_reg <= '0;
         else if (scan_tick) blft_reg <= n_ent;
         else if (burst_hit) blft_reg <= blft_reg - 5'h01;
         if (!run || scan_tick) bcnt_reg <= '0;
         else if (burst_hit) bcnt_reg <= BURST_CYC - 16'h1;
         else if (bcnt_reg != '0) bcnt_reg <= bcnt_reg - 16'h1;
      end
   end

   // Conversion control
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pend_reg <= 1'b0;
         busy_reg <= 1'b0;
         tag_reg <= '0;
         qidx_reg <= '0;
         tcnt_reg <= '0;
         ovr_reg <= 1'b0;
         o_conv_start <= 1'b0;
         o_conv_chan <= '0;
         o_conv_diff <= 1'b0;
         o_conv_range <= RANGE_PM10_VOLT;
         o_sample_clock_echo_out <= 1'b0;
      end else begin
         o_conv_start <= issue;
         if (!run) pend_reg <= 1'b0;
         else if (sample_tick) pend_reg <= 1'b1;
         else if (issue) pend_reg <= 1'b0;
         if (issue) busy_reg <= 1'b1;
         else if (i_conv_done) busy_reg <= 1'b0;
         // A tick on a still-pending sample is lost; set wins over clear
         if (sample_tick & pend_reg & ~issue) ovr_reg <= 1'b1;
         else if (apb_wr & hit_status & i_pwdata[ST_OVERRUN]) ovr_reg <= 1'b0;
         if (state_reg != ASQ_RUN && state_next == ASQ_RUN) begin
            qidx_reg <= '0;
            tcnt_reg <= '0;
         end else if (issue) begin
            tag_reg <= qidx_reg;
            qidx_reg <= (qidx_reg == qlen_reg) ? 4'h0
                        : qidx_reg + 4'h1;
            tcnt_reg <= rearm ? 32'h0 : tcnt_reg + 32'h1;
            o_conv_diff <= entry[ENT_DIFF];
            o_conv_chan <= entry[ENT_DIFF] ? {1'b0, entry[2:0]}
                           : entry[3:0];
            o_conv_range <= entry[ENT_RANGE_LO+1:ENT_RANGE_LO];
         end
         o_sample_clock_echo_out <= ext_sel ? ext_s
                                    : sample_tick;
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_queue_wrap: assert property (
      issue && qidx_reg == qlen_reg && state_next == ASQ_RUN
      |=> qidx_reg == 4'h0)
      else $error("queue index did not wrap to zero");
   a_diff_pair: assert property (
      o_conv_start && o_conv_diff |-> o_conv_chan[3] == 1'b0)
      else $error("differential channel above seven");
   a_ext_echo: assert property (
      ext_sel && $rose(ext_s) && $stable(ctrl_reg)
      |=> o_sample_clock_echo_out ##1 $stable(o_sample_clock_echo_out)
          || !ext_s)
      else $error("external clock pulse not echoed");
   a_int_echo: assert property (
      !ext_sel && sample_tick |=> o_sample_clock_echo_out)
      else $error("scan clock not driven on echo pin");
   a_burst_gap: assert property (
      burst_hit && blft_reg > 5'h01 && !cmd_stop && !rearm
      |=> !burst_hit [*8])
      else $error("burst samples closer than burst period");
   a_ext_burst: assert property (
      ext_sel |-> burst && !even_hit)
      else $error("external pacing without burst");
   a_edge_fire: assert property (
      state_reg == ASQ_ARMED && !lvl_mode && !inv_mode && acq_trigger_in_rise
      && !cmd_stop |=> state_reg == ASQ_RUN)
      else $error("rising edge did not start acquisition");
   a_level_fire: assert property (
      state_reg == ASQ_ARMED && lvl_mode && inv_mode && !acq_trigger_in_s
      && !cmd_stop |=> state_reg == ASQ_RUN)
      else $error("low level did not start acquisition");
   a_run_holds: assert property (
      run && !cmd_stop && !rearm |=> run)
      else $error("acquisition left run without rearm or stop");
   a_rearm_count: assert property (
      rearm && !cmd_stop |=> state_reg == ASQ_ARMED && tcnt_reg == '0)
      else $error("rearm did not return to armed");
   a_start_room: assert property (
      o_conv_start |-> $past(f_in_ready) && busy_reg)
      else $error("conversion started without buffer room");
   a_idle_holds: assert property (
      state_reg == ASQ_IDLE && !cmd_start |=> state_reg == ASQ_IDLE)
      else $error("acquisition left idle without start command");

   c_burst_scan: cover property (burst_hit ##[1:300] burst_hit);
   c_rearm: cover property (rearm ##[1:1000] state_reg == ASQ_RUN);
   c_even: cover property (even_hit ##[1:1000] even_hit);
   c_fifo_full: cover property (run && !f_in_ready);
   c_level_fire: cover property (state_reg == ASQ_ARMED && lvl_mode ##1 run);
endmodule : asq_scan_seq

// >>> asq_conv_model.sv
// Converter model that answers each start after a short or long delay
`timescale 1ns/10ps
module asq_conv_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic [3:0] i_chan,
   input wire logic i_diff,
   input wire logic [1:0] i_range,
   input wire logic i_slow,
   output logic o_done,
   output logic [15:0] o_data
);
   logic [15:0] smp;
   int cnt;
   // Data lines show the inverse outside the done cycle, never a stale sample
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= 0;
         o_done <= 1'b0;
         o_data <= 16'h0000;
         smp <= 16'h0000;
      end else begin
         o_done <= 1'b0;
         o_data <= ~smp;
         if (i_start) begin
            smp <= {7'h5A, i_range, i_diff, 2'h0, i_chan};
            cnt <= i_slow ? 20 : 2;
         end else if (cnt == 1) begin
            o_done <= 1'b1;
            o_data <= smp;
            cnt <= 0;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : asq_conv_model

// >>> tb_analog_scan_sequencer.sv
// Testbench: APB-driven scenarios for the scan sequencer
`timescale 1ns/10ps
module tb_analog_scan_sequencer;
   import asq_pkg::*;
   logic clk, rst_n, psel, pen, pwr, ext, trg, slow, done, err;
   logic pready, pslverr, echo, echo_q, cst, cdiff;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] cchan;
   logic [1:0] crange, m;
   logic [15:0] cdata;
   int failures, n_tests, n_st, n_echo, t_now, b, eb;
   int t_st[$];
   logic [6:0] c_st[$];
   // Entry 1 is a pair written as 9: only the low three bits pick the pair
   logic [6:0] went[4] = '{7'h25, 7'h19, 7'h6F, 7'h25};
   logic [6:0] xent[4] = '{7'h25, 7'h11, 7'h6F, 7'h25};
   logic [31:0] rst_v[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFA, 32'h1,
                             32'h0, 32'h0};

   asq_scan_seq dut_u (.i_clk(clk), .i_arst_n(rst_n), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
      .i_ext_sample_clock_in(ext), .i_acq_trigger_in(trg),
      .o_sample_clock_echo_out(echo), .o_conv_start(cst),
      .o_conv_chan(cchan), .o_conv_diff(cdiff), .o_conv_range(crange),
      .i_conv_done(done), .i_conv_data(cdata));
   asq_conv_model conv_u (.i_clk(clk), .i_arst_n(rst_n), .i_start(cst),
      .i_chan(cchan), .i_diff(cdiff), .i_range(crange), .i_slow(slow),
      .o_done(done), .o_data(cdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      t_now <= t_now + 1;
      echo_q <= echo;
      if (echo === 1'b1 && echo_q === 1'b0) n_echo <= n_echo + 1;
      if (cst === 1'b1) begin
         n_st <= n_st + 1;
         t_st.push_back(t_now);
         c_st.push_back({crange, cdiff, cchan});
      end
   end

   function automatic logic [31:0] xw(input int i);
      return {1'b1, 11'h000, 4'(i), 7'h5A, xent[i][6:5], xent[i][4],
              2'h0, xent[i][3:0]};
   endfunction : xw

   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic close_out;
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   // One APB transfer; waits for pready with a bound, no fixed latency
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic drain;
      int k;
      k = 0;
      do begin
         apb(1'b0, OFF_DATA, 32'h0);
         k++;
      end while (rd[31] === 1'b1 && k < 20);
   endtask : drain

   task automatic wait_st(input int n);
      int k;
      k = 0;
      while (n_st < n && k < 5000) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_st

   initial begin
      {rst_n, psel, pen, pwr, ext, trg, slow} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk("reset value", rd, rst_v[i]);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      apb(1'b1, 12'h07C, 32'h7F);
      apb(1'b0, 12'h07C, 32'h0);
      chk("last entry", rd, 32'h7F);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h040 + 12'(4 * i), 32'(went[i]));
      end
      apb(1'b1, OFF_QLEN, 32'h3);
      apb(1'b1, OFF_PACER, 32'h190);
      apb(1'b1, OFF_CMD, 32'h1);
      // Nobody reads, so the buffer fills, refuses and overruns
      repeat (3000) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         chk("conv entry", 32'(c_st[i]),
             32'(xent[i % 4]));
      end
      for (int i = 1; i < 4; i++) begin
         chk("even spacing", 32'(t_st[i] - t_st[i - 1]), 32'h64);
      end
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("state run", 32'(rd[1:0]), 32'h2);
      chk("fifo full", 32'(rd[12:8]), 32'h10);
      chk("overrun", 32'(rd[16]), 32'h1);
      apb(1'b1, OFF_CMD, 32'h2);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("state idle", 32'(rd[1:0]), 32'h0);
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, OFF_DATA, 32'h0);
         chk("fifo word", rd & 32'h800F_FFFF, xw(i % 4));
      end
      apb(1'b0, OFF_DATA, 32'h0);
      chk("fifo empty", 32'(rd[31]), 32'h0);
      apb(1'b1, OFF_STATUS, 32'h0001_0000);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("overrun clear", 32'(rd[16]), 32'h0);
      // Internal pacer in burst mode, echo counted against starts
      b = n_st;
      eb = n_echo;
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_PACER, 32'h7D0);
      apb(1'b1, OFF_CMD, 32'h1);
      wait_st(b + 4);
      apb(1'b1, OFF_CMD, 32'h2);
      repeat (20) @(posedge clk);
      for (int i = 1; i < 4; i++) begin
         chk("burst spacing", 32'(t_st[b + i] - t_st[b + i - 1]),
             32'(BURST_CYC));
      end
      chk("echo count", 32'(n_echo - eb), 32'(n_st - b));
      drain();
      // External clock with burst bit clear still runs in burst
      b = n_st;
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CMD, 32'h1);
      repeat (10) @(posedge clk);
      chk("echo low", 32'(echo), 32'h0);
      ext <= 1'b1;
      repeat (5) @(posedge clk);
      chk("echo high", 32'(echo), 32'h1);
      ext <= 1'b0;
      repeat (5) @(posedge clk);
      chk("echo back", 32'(echo), 32'h0);
      repeat (1000) @(posedge clk);
      chk("ext count", 32'(n_st - b), 32'h4);
      chk("ext spacing", 32'(t_st[b + 1] - t_st[b]),
          32'(BURST_CYC));
      apb(1'b1, OFF_CMD, 32'h2);
      drain();
      // Every trigger mode: edge modes see a wrong-way move first, level modes hold the inactive level, then the real one
      apb(1'b1, OFF_CTRL, 32'h8);
      for (int c = 0; c < 4; c++) begin
         m = 2'(c);
         trg <= m[0] ? m[1] : ~m[1];
         apb(1'b1, OFF_ACQ_TRIGGER_IN, 32'(m));
         apb(1'b1, OFF_CMD, 32'h1);
         trg <= m[1];
         repeat (8) @(posedge clk);
         apb(1'b0, OFF_STATUS, 32'h0);
         chk("armed", 32'(rd[1:0]), 32'h1);
         trg <= ~m[1];
         repeat (8) @(posedge clk);
         apb(1'b0, OFF_STATUS, 32'h0);
         chk("fired", 32'(rd[1:0]), 32'h2);
         apb(1'b1, OFF_CMD, 32'h2);
      end
      drain();
      // Retrigger, slow converter, an extra edge while acquiring
      apb(1'b1, OFF_CTRL, 32'hC);
      apb(1'b1, OFF_TCOUNT, 32'h3);
      // Even pacing, one sample per 100 cycles: three fit in each wait
      apb(1'b1, OFF_PACER, 32'h190);
      apb(1'b1, OFF_ACQ_TRIGGER_IN, 32'h0);
      trg <= 1'b0;
      slow <= 1'b1;
      apb(1'b1, OFF_CMD, 32'h1);
      b = n_st;
      repeat (8) @(posedge clk);
      trg <= 1'b1;
      repeat (30) @(posedge clk);
      trg <= 1'b0;
      repeat (20) @(posedge clk);
      trg <= 1'b1;
      repeat (600) @(posedge clk);
      chk("per trigger", 32'(n_st - b), 32'h3);
      chk("first entry", 32'(c_st[b]), 32'(xent[0]));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("rearmed", 32'(rd[1:0]), 32'h1);
      trg <= 1'b0;
      repeat (8) @(posedge clk);
      trg <= 1'b1;
      repeat (600) @(posedge clk);
      chk("second trigger", 32'(n_st - b), 32'h6);
      apb(1'b1, OFF_CMD, 32'h2);
      close_out();
   end

   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule : tb_analog_scan_sequencer
